// ---- sim/adccc_checker.sv ----
// Port assertions for the converter control block.
// Assumes a bind to adccc_top, one clock, clock enable held high.
`timescale 1ns/100ps
`default_nettype none
module adccc_checker (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       core_done,
	input wire logic       core_start,
	input wire logic       converter_power_on,
	input wire logic [8:0] analog_input_sel,
	input wire logic       conversion_irq
);
	logic busy_sh;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Busy shadow built from the core handshake
	always @(posedge clk)
		busy_sh <= !rst_n ? 1'b0 : core_start ? 1'b1 : core_done ? 1'b0 : busy_sh;
	// ------
	// Assertions
	// ------
	sequence ctl_rd;
		reg_rd && reg_addr == 8'hE8;
	endsequence
	start_pulse_a: assert property (core_start |=> !core_start)
		else $error("start pulse too long");
	busy_read_a: assert property (core_start ##0 ctl_rd |=> reg_rdata[6])
		else $error("busy low in conversion");
	done_read_a: assert property (busy_sh && core_done ##1 ctl_rd |=> reg_rdata[7:6] == 2'b10)
		else $error("completion not shown");
	idle_rdata_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without read");
	power_isolate_a: assert property (!converter_power_on [*2] |-> analog_input_sel == 9'h000)
		else $error("input connected while off");
	sel_onehot_a: assert property ($onehot0(analog_input_sel))
		else $error("several inputs connected");
	busy_nostart_a: assert property (busy_sh |-> !core_start)
		else $error("start while busy");
	done_nostart_a: assert property (conversion_irq && $past(conversion_irq) |-> !core_start)
		else $error("start while done flag set");
endmodule // adccc_checker
bind adccc_top adccc_checker u_adccc_checker (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_done(core_done), .core_start(core_start),
	.converter_power_on(converter_power_on), .analog_input_sel(analog_input_sel),
	.conversion_irq(conversion_irq));
`default_nettype wire

// ---- sim/adccc_core_model.sv ----
// Behavioural converter core on the far side of the block.
// Assumes start pulses arrive only while the core is idle.
`timescale 1ns/100ps
`default_nettype none
module adccc_core_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        core_start,
	input  wire logic [4:0]  len,
	input  wire logic [11:0] value,
	output var  logic        core_done,
	output wire logic [11:0] core_result
);
	logic [4:0] left;
	// Count the conversion down, one-cycle done at the end
	always @(posedge clk) begin
		core_done <= 1'b0;
		if (!rst_n)
			left <= 5'h00;
		else if (core_start)
			left <= len;
		else if (left != 5'h00) begin
			left <= left - 5'h01;
			core_done <= (left == 5'h01);
		end
	end
	// Result valid only beside done, inverse otherwise
	assign core_result = core_done ? value : ~value;
endmodule // adccc_core_model
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the converter control block.
// Assumes a 10 MHz clock and the core model on the far side.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        pwm_centre = 1'b0, pwm_end = 1'b0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
	logic [4:0]  lines = 5'h00, len = 5'h08;
	logic [11:0] value = 12'h000, core_result;
	logic [8:0]  analog_input_sel;
	logic        core_done, core_start, converter_power_on, conversion_irq;
	int          miscompares = 0, tests_run = 0;
	adccc_top u_adccc_top (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pwm_level(lines[2:0]), .pwm_centre(pwm_centre), .pwm_end(pwm_end),
		.pin_p0_4(lines[3]), .pin_p1_3(lines[4]), .core_done(core_done),
		.core_result(core_result), .core_start(core_start), .conversion_irq(conversion_irq),
		.converter_power_on(converter_power_on), .analog_input_sel(analog_input_sel));
	adccc_core_model u_adccc_core_model (.clk(clk), .rst_n(rst_n), .core_start(core_start),
		.len(len), .value(value), .core_done(core_done), .core_result(core_result));
	initial forever #50 clk = ~clk;
	// ------
	// Tasks
	// ------
	task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
		tests_run++;
		if (exp !== got) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	function automatic logic [8:0] exp_sel(logic p, logic [3:0] c);
		return (p && c <= 4'h8) ? 9'h001 << c : 9'h000;
	endfunction
	// One bus cycle; rd_val gets the data of the previous cycle's read
	task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		rd_val = reg_rdata;
	endtask
	task automatic idle(int n);
		repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
	endtask
	task automatic rdchk(string what, logic [7:0] a, logic [7:0] exp);
		bus(1'b0, 1'b1, a, 8'h00);
		idle(1);
		chk(what, {4'h0, exp}, {4'h0, rd_val});
	endtask
	// Back-to-back reads until busy clears
	task automatic wait_done();
		int n = 0;
		bus(1'b0, 1'b1, 8'hE8, 8'h00);
		do begin
			bus(1'b0, 1'b1, 8'hE8, 8'h00);
			n++;
		end while (rd_val[6] !== 1'b0 && n < 40);
		idle(1);
		if (n >= 40) begin
			chk("busy wait", 12'h000, 12'h001);
			conclude();
		end
	endtask
	task automatic soft_conv(logic [7:0] a, logic [7:0] d);
		value = 12'($urandom);
		len = 5'($urandom_range(6, 20));
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b1, 8'hE8, 8'h00);
		bus(1'b1, 1'b0, 8'hE8, 8'h00);
		chk("busy", 12'h040, {4'h0, rd_val});
		bus(1'b0, 1'b1, 8'hE8, 8'h00);
		idle(1);
		chk("zero write", 12'h040, {4'h0, rd_val});
		wait_done();
		chk("done", 12'h080, {4'h0, rd_val});
		chk("irq", 12'h001, {11'h000, conversion_irq});
		rdchk("high result", 8'hC3, value[11:4]);
		rdchk("low result", 8'hC2, {4'h0, value[3:0]});
		bus(1'b1, 1'b0, 8'hE9, 8'h86);
		rdchk("refused", 8'hE8, 8'h80);
		bus(1'b1, 1'b0, 8'hE9, 8'h07);
		bus(1'b1, 1'b0, 8'hE8, 8'h80);
		rdchk("cleared", 8'hE8, 8'h00);
		chk("irq low", 12'h000, {11'h000, conversion_irq});
	endtask
	task automatic ev(logic right, int s, int c, logic loc);
		int k;
		k = s < 3 ? (right ? s : (s + 1) % 3) : (right ^ loc ? 3 : 4);
		if (c < 2)
			lines[k] <= (c == 1);
		else
			{pwm_end, pwm_centre} <= (right ^ (c == 3)) ? 2'b01 : 2'b10;
		idle(1);
		{pwm_end, pwm_centre} <= 2'b00;
	endtask
	// Wrong source first, then the selected one, then one while busy
	task automatic hw(int s, int c, logic loc);
		logic       lvl;
		logic [7:0] dly;
		int         n;
		lvl = (c == 0);
		dly = 8'($urandom_range(0, 5));
		len = 5'($urandom_range(8, 20));
		lines <= {5{lvl}};
		bus(1'b1, 1'b0, 8'hE3, dly);
		bus(1'b1, 1'b0, 8'hE1, {1'b0, loc, 2'b00, 2'(c), 2'b11});
		bus(1'b1, 1'b0, 8'hE8, {2'b00, 2'(s), 4'h0});
		ev(1'b0, s, c, loc);
		idle(dly + 6);
		rdchk("wrong source", 8'hE8, {2'b00, 2'(s), 4'h0});
		ev(1'b1, s, c, loc);
		for (n = 1; core_start !== 1'b1 && n < 40; n++)
			idle(1);
		chk("delay", 12'(dly) + 12'h003, 12'(n));
		if (n >= 40)
			conclude();
		lines <= {5{lvl}};
		idle(1);
		ev(1'b1, s, c, loc);
		wait_done();
		chk("hw done", {4'h0, 2'b10, 2'(s), 4'h0}, {4'h0, rd_val});
		bus(1'b1, 1'b0, 8'hE9, 8'h07);
		idle(dly + 6);
		rdchk("not queued", 8'hE8, {2'b00, 2'(s), 4'h0});
	endtask
	// ------
	// Scenarios
	// ------
	initial begin
		void'($urandom(72));
		idle(12);
		rst_n <= 1'b1;
		rdchk("control zero", 8'hE8, 8'h00);
		rdchk("control one", 8'hE1, 8'h00);
		bus(1'b1, 1'b0, 8'hA0, 8'hFF);
		rdchk("unmapped", 8'hA0, 8'h00);
		// Frozen clock enable ignores a start write
		ce <= 1'b0;
		bus(1'b1, 1'b0, 8'hE8, 8'h4F);
		ce <= 1'b1;
		rdchk("frozen", 8'hE8, 8'h00);
		for (int i = 0; i < 32; i++) begin
			bus(1'b1, 1'b0, 8'hE1, {7'h00, i[4]});
			bus(1'b1, 1'b0, 8'hE8, {4'h0, i[3:0]});
			idle(2);
			chk("power", {11'h000, i[4]}, {11'h000, converter_power_on});
			chk("select", {3'h0, exp_sel(i[4], i[3:0])}, {3'h0, analog_input_sel});
		end
		bus(1'b1, 1'b0, 8'hE2, 8'h02);
		soft_conv(8'hE8, 8'h40);
		soft_conv(8'hE9, 8'h86);
		bus(1'b1, 1'b0, 8'hE1, 8'h05);
		lines <= 5'h01;
		idle(8);
		rdchk("software only", 8'hE8, 8'h00);
		for (int k = 0; k < 16; k++) begin
			if (k < 10)
				hw(k < 8 ? k / 2 : 0, k < 8 ? k % 2 : k - 6, k == 7);
			else
				hw($urandom_range(0, 3), $urandom_range(0, 1), 1'($urandom_range(0, 1)));
		end
		conclude();
	end
endmodule // tb
`default_nettype wire

// ---- src/adccc_delay.v ----
// Nine-bit trigger delay counter of the converter control block.
// Assumes a synchronous clock enable and synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
`include "adccc_regs.vh"

module adccc_delay (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       ce,
	input  wire       load,
	input  wire [8:0] delay,
	output reg        fire,
	output wire       pending
);

	reg        run;
	reg  [8:0] count;

	assign pending = run;

	// Load on trigger, count down, fire once at zero
	always @(posedge clk) begin
		if (!rst_n) begin
			run   <= 1'b0;
			count <= `ADCCC_RESET_DELAY;
			fire  <= 1'b0;
		end else if (ce) begin
			fire <= 1'b0;
			if (load && !run) begin
				if (delay == 9'h000) begin
					fire <= 1'b1;
				end else begin
					run   <= 1'b1;
					count <= delay - 9'h001;
				end
			end else if (run) begin
				if (count == 9'h000) begin
					run  <= 1'b0;
					fire <= 1'b1;
				end else begin
					count <= count - 9'h001;
				end
			end
		end
	end

endmodule // adccc_delay

`default_nettype wire

// ---- src/adccc_regs.vh ----
// Register offsets, field positions, codes and reset values of the
// converter control block.
// Assumes an 8-bit register port and a 10 MHz system clock.
//
// Functional notes
// - Done flag, control zero bit 7, set on completion, cleared only by writing zero.
// - While done flag is one, no new conversion starts from any source.
// - Writing one to start/busy launches a conversion; writing zero does nothing.
// - Start/busy reads one during conversion, cleared by hardware on completion.
// - Trigger source bits 5:4: PWM0, PWM2, PWM4, external start pin.
// - Channel select bits 3:0: inputs 0 to 7, 1000 band-gap, others reserved.
// - Converter enable zero disconnects every analog input from sample-and-hold.
// - Start pin location bit selects pin P0.4 when zero, P1.3 when one.
// - Start pin location change takes effect right after the write.
// - Trigger condition bits 3:2: falling, rising, period centre, period end.
// - Hardware trigger allow zero: software only; one: external source too.
// - External triggers during busy are discarded silently.
// - Converter enable powers the converter circuit off at zero, on at one.
// - Control zero supports single-bit set and clear besides byte writes.
// - Accepted hardware trigger sets start/busy like a software start.
// - On completion raise request if enabled; store result high 8, low 4.
// - After an external trigger, count a programmable 9-bit delay first.
`ifndef ADCCC_REGS_VH
`define ADCCC_REGS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADCCC_OFS_CTRL_ONE   8'hE1
`define ADCCC_OFS_CTRL_TWO   8'hE2
`define ADCCC_OFS_DELAY_LO   8'hE3
`define ADCCC_OFS_CTRL_ZERO  8'hE8
`define ADCCC_OFS_BIT_OP     8'hE9
`define ADCCC_OFS_RES_LOW    8'hC2
`define ADCCC_OFS_RES_HIGH   8'hC3

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ADCCC_DONE_BIT       7
`define ADCCC_BUSY_BIT       6
`define ADCCC_SRC_HI         5
`define ADCCC_SRC_LO         4
`define ADCCC_CHAN_HI        3
`define ADCCC_CHAN_LO        0
`define ADCCC_PINLOC_BIT     6
`define ADCCC_COND_HI        3
`define ADCCC_COND_LO        2
`define ADCCC_HWTRIG_BIT     1
`define ADCCC_POWER_BIT      0
`define ADCCC_IRQEN_BIT      1
`define ADCCC_DLY8_BIT       0
`define ADCCC_CTRL_ONE_MASK  8'h4F

// ---------------------------------------------------------------
// Codes and reset values
// ---------------------------------------------------------------
`define ADCCC_SRC_PIN        2'h3
`define ADCCC_COND_FALL      2'h0
`define ADCCC_COND_RISE      2'h1
`define ADCCC_COND_CENTRE    2'h2
`define ADCCC_COND_END       2'h3
`define ADCCC_CHAN_BANDGAP   4'h8
`define ADCCC_RESET_BYTE     8'h00
`define ADCCC_RESET_DELAY    9'h000

`endif

// ---- src/adccc_top.v ----
// Conversion control around a 12-bit successive-approximation converter.
// Assumes the register port, PWM signals and pins are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "adccc_regs.vh"

module adccc_top (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        ce,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	input  wire [2:0]  pwm_level,
	input  wire        pwm_centre,
	input  wire        pwm_end,
	input  wire        pin_p0_4,
	input  wire        pin_p1_3,
	input  wire        core_done,
	input  wire [11:0] core_result,
	output reg         core_start,
	output wire        converter_power_on,
	output wire [8:0]  analog_input_sel,
	output reg         conversion_irq
);

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	reg        conversion_done_flag;
	reg        convert_start_busy;
	reg  [1:0] ext_trigger_source_sel;
	reg  [3:0] input_channel_sel;
	reg        start_pin_location_sel;
	reg  [1:0] ext_trigger_condition_sel;
	reg        hw_trigger_allow;
	reg        power_bit;
	reg        irq_enable;
	reg  [8:0] trigger_delay_count;
	reg  [7:0] result_high_byte;
	reg  [3:0] result_low_byte;
	reg        src_prev;

	wire       wr_ctrl_zero;
	wire       wr_bit_op;
	wire [7:0] next_ctrl_zero;
	wire [7:0] cur_ctrl_zero;
	wire       src_level;
	wire       src_rise;
	wire       src_fall;
	reg        trig_event;
	wire       delay_fire;
	wire       delay_pending;
	wire       hw_start;
	wire       sw_start;

	// Bit operation: wdata[7]=set(1)/clear(0), wdata[2:0]=bit index
	function [7:0] bit_apply;
		input [7:0] cur;
		input [7:0] cmd;
		reg   [7:0] sel;
		begin
			sel = 8'h01 << cmd[2:0];
			bit_apply = cmd[7] ? (cur | sel) : (cur & ~sel);
		end
	endfunction

	assign cur_ctrl_zero  = {conversion_done_flag, convert_start_busy,
	                         ext_trigger_source_sel, input_channel_sel};
	assign wr_ctrl_zero   = reg_wr && (reg_addr == `ADCCC_OFS_CTRL_ZERO);
	assign wr_bit_op      = reg_wr && (reg_addr == `ADCCC_OFS_BIT_OP);
	assign next_ctrl_zero = wr_bit_op ? bit_apply(cur_ctrl_zero, reg_wdata)
	                                  : reg_wdata;

	// ---------------------------------------------------------------
	// Trigger source selection and edge detection
	// ---------------------------------------------------------------
	// Pin routed immediately from the location bit
	assign src_level = (ext_trigger_source_sel == `ADCCC_SRC_PIN) ?
		(start_pin_location_sel ? pin_p1_3 : pin_p0_4) :
		pwm_level[ext_trigger_source_sel];
	assign src_rise = src_level && !src_prev;
	assign src_fall = !src_level && src_prev;

	// Condition select
	always @* begin
		case (ext_trigger_condition_sel)
			`ADCCC_COND_FALL:   trig_event = src_fall;
			`ADCCC_COND_RISE:   trig_event = src_rise;
			`ADCCC_COND_CENTRE: trig_event = pwm_centre;
			default:            trig_event = pwm_end;
		endcase
	end

	// Previous sample of selected source
	always @(posedge clk) begin
		if (!rst_n) begin
			src_prev <= 1'b0;
		end else if (ce) begin
			src_prev <= src_level;
		end
	end

	// Trigger delay counter
	adccc_delay u_delay (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.load    (hw_trigger_allow && trig_event && !convert_start_busy
		          && !conversion_done_flag && !delay_pending),
		.delay   (trigger_delay_count),
		.fire    (delay_fire),
		.pending (delay_pending)
	);

	assign hw_start = delay_fire && hw_trigger_allow && !convert_start_busy
	                  && !conversion_done_flag;
	assign sw_start = (wr_ctrl_zero || wr_bit_op) && next_ctrl_zero[`ADCCC_BUSY_BIT]
	                  && !convert_start_busy && !conversion_done_flag;

	// ---------------------------------------------------------------
	// Control zero: done flag, busy, source, channel
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			conversion_done_flag   <= 1'b0;
			convert_start_busy     <= 1'b0;
			ext_trigger_source_sel <= 2'h0;
			input_channel_sel      <= 4'h0;
			core_start             <= 1'b0;
		end else if (ce) begin
			core_start <= 1'b0;
			if (wr_ctrl_zero || wr_bit_op) begin
				ext_trigger_source_sel <= next_ctrl_zero[`ADCCC_SRC_HI:`ADCCC_SRC_LO];
				input_channel_sel      <= next_ctrl_zero[`ADCCC_CHAN_HI:`ADCCC_CHAN_LO];
				if (!next_ctrl_zero[`ADCCC_DONE_BIT]) begin
					conversion_done_flag <= 1'b0;
				end
			end
			// Completion set wins over a clearing write
			if (core_done && convert_start_busy) begin
				conversion_done_flag <= 1'b1;
				convert_start_busy   <= 1'b0;
			end else if (sw_start || hw_start) begin
				convert_start_busy <= 1'b1;
				core_start         <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Control one, control two, delay, result capture
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			start_pin_location_sel    <= 1'b0;
			ext_trigger_condition_sel <= 2'h0;
			hw_trigger_allow          <= 1'b0;
			power_bit                 <= 1'b0;
			irq_enable                <= 1'b0;
			trigger_delay_count       <= `ADCCC_RESET_DELAY;
			result_high_byte          <= `ADCCC_RESET_BYTE;
			result_low_byte           <= 4'h0;
			conversion_irq            <= 1'b0;
		end else if (ce) begin
			if (reg_wr && reg_addr == `ADCCC_OFS_CTRL_ONE) begin
				start_pin_location_sel    <= reg_wdata[`ADCCC_PINLOC_BIT];
				ext_trigger_condition_sel <= reg_wdata[`ADCCC_COND_HI:`ADCCC_COND_LO];
				hw_trigger_allow          <= reg_wdata[`ADCCC_HWTRIG_BIT];
				power_bit                 <= reg_wdata[`ADCCC_POWER_BIT];
			end
			if (reg_wr && reg_addr == `ADCCC_OFS_CTRL_TWO) begin
				irq_enable             <= reg_wdata[`ADCCC_IRQEN_BIT];
				trigger_delay_count[8] <= reg_wdata[`ADCCC_DLY8_BIT];
			end
			if (reg_wr && reg_addr == `ADCCC_OFS_DELAY_LO) begin
				trigger_delay_count[7:0] <= reg_wdata;
			end
			if (core_done && convert_start_busy) begin
				result_high_byte <= core_result[11:4];
				result_low_byte  <= core_result[3:0];
			end
			// Level request follows the done flag when enabled
			conversion_irq <= irq_enable &&
				(conversion_done_flag || (core_done && convert_start_busy)) &&
				!((wr_ctrl_zero || wr_bit_op) && !next_ctrl_zero[`ADCCC_DONE_BIT] &&
				  !(core_done && convert_start_busy));
		end
	end

	// ---------------------------------------------------------------
	// Analog side
	// ---------------------------------------------------------------
	assign converter_power_on = power_bit;
	assign analog_input_sel   = (power_bit && input_channel_sel <= `ADCCC_CHAN_BANDGAP) ?
		(9'h001 << input_channel_sel) : 9'h000;

	// ---------------------------------------------------------------
	// Read port: data one cycle after the strobe
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			if (reg_rd) begin
				case (reg_addr)
					`ADCCC_OFS_CTRL_ZERO: reg_rdata <= cur_ctrl_zero;
					`ADCCC_OFS_BIT_OP:    reg_rdata <= cur_ctrl_zero;
					`ADCCC_OFS_CTRL_ONE:  reg_rdata <= {1'b0, start_pin_location_sel, 2'b00,
					                        ext_trigger_condition_sel, hw_trigger_allow,
					                        power_bit};
					`ADCCC_OFS_CTRL_TWO:  reg_rdata <= {6'h00, irq_enable,
					                        trigger_delay_count[8]};
					`ADCCC_OFS_DELAY_LO:  reg_rdata <= trigger_delay_count[7:0];
					`ADCCC_OFS_RES_HIGH:  reg_rdata <= result_high_byte;
					`ADCCC_OFS_RES_LOW:   reg_rdata <= {4'h0, result_low_byte};
					default:              reg_rdata <= 8'h00;
				endcase
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

endmodule // adccc_top

`default_nettype wire
